// ---- design/hcd_device.sv ----
`timescale 1ns/1ps
module hcd_device (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link to the host
	hcd_link_if.dev link,
	// Bus mode and identity straps
	input wire logic busWide16,
	input wire logic serialNineBitMode,
	input wire logic [1:0] idPinState,
	input wire logic [1:0] moduleId,
	// Display memory side
	output logic memWrStrobe,
	output logic [15:0] memWrData,
	input wire logic [15:0] memRdData,
	// Control fields
	output hcd_pkg::hcd_cfg_t cfg
);
	import hcd_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		hcd_cfg_t cfg; // All control fields
		logic paramPending; // Next command byte is a parameter
		logic [7:0] pendingOp; // Opcode awaiting its parameter
		logic [1:0] statIdx; // Next status byte to return
		logic [15:0] rdData; // Read answer
		logic rdValid; // Read answer pulse
		logic memWrStrobe; // Display write pulse
		logic [15:0] memWrData; // Display write word
	} hcd_dev_state_t;

	hcd_dev_state_t q; // Registered state
	hcd_dev_state_t d; // Next state

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		logic isData; // Data or control cycle
		logic [7:0] cmdByte; // Low byte of the bus
		logic [15:0] busWord; // Bus word masked to width
		logic [1:0] shareIdx; // Index of a shared register
		isData = 1'b0;
		cmdByte = 8'h00;
		busWord = 16'h0000;
		shareIdx = 2'h0;
		d = q;
		// Pulses last one cycle
		d.rdValid = 1'b0;
		d.memWrStrobe = 1'b0;
		if (!link.hwResetB) begin
			// Hardware reset pin
			d.cfg = CFG_RESET;
			d.paramPending = 1'b0;
			d.statIdx = 2'h0;
		end else if (link.strobe) begin
			// Token replaces the select pin in nine-bit serial
			isData = serialNineBitMode ? link.tokenCd
				: link.cmdDataSelect;
			// Eight-bit modes carry only the low byte
			busWord = busWide16 ? link.wdata : {8'h00, link.wdata[7:0]};
			// Upper lines never reach the decoder
			cmdByte = link.wdata[7:0];
			shareIdx = q.pendingOp[1:0];
			if (isData && !link.rdNotWr) begin
				// One display-memory write
				d.memWrStrobe = 1'b1;
				d.memWrData = busWord;
			end else if (isData) begin
				// One display-memory read
				d.rdValid = 1'b1;
				d.rdData = busWide16 ? memRdData : {8'h00, memRdData[7:0]};
			end else if (link.rdNotWr) begin
				// Status bytes in a fixed order, then wrap
				d.rdValid = 1'b1;
				unique case (q.statIdx)
					2'h0: d.rdData = {8'h00, 1'b0,
						q.cfg.panelCtlField[2:1],
						q.cfg.addrIncrementCtl[AIC_WINMODE],
						q.cfg.displayCtlFlags[2], 3'h0};
					2'h1: d.rdData = {8'h00, VERSION_BIT,
						q.cfg.biasPotValue[6:0]};
					default: d.rdData = {8'h00, PRODUCT_CODE,
						idPinState, moduleId};
				endcase
				d.statIdx = (q.statIdx == STAT_LAST_IDX) ? 2'h0
					: q.statIdx + 2'h1;
			end else if (q.paramPending) begin
				// Next command write is the parameter of the pending opcode
				d.paramPending = 1'b0;
				d.statIdx = 2'h0;
				unique casez (q.pendingOp)
					OP_POT: d.cfg.biasPotValue = cmdByte;
					OP_NIV: d.cfg.lineInversionCount = cmdByte[4:0];
					OP_CEN: d.cfg.lastCommonLine = cmdByte;
					OP_DST: d.cfg.partialStartLine = cmdByte;
					OP_DEN: d.cfg.partialEndLine = cmdByte;
					OP_NVM_OP: d.cfg.nvmProgramCtl = cmdByte[4:0];
					OP_NVM_MASK: d.cfg.nvmWriteMask = cmdByte[6:0];
					8'b1111_01??: begin
						// Shared codes pick their register bank
						if (q.cfg.nvmProgramCtl[NVM_SHARE_BIT]) begin
							d.cfg.nvmRegs[shareIdx] = cmdByte;
						end else begin
							d.cfg.windowRegs[shareIdx] = cmdByte;
						end
					end
					// Test, fixed-line and program parameters unused
					default: d.cfg = q.cfg;
				endcase
			end else begin
				// Opcode decode
				d.statIdx = 2'h0;
				d.pendingOp = cmdByte;
				unique casez (cmdByte)
					8'b0000_????:
						d.cfg.columnPointer[3:0] = cmdByte[3:0];
					8'b0001_0???:
						d.cfg.columnPointer[6:4] = cmdByte[2:0];
					8'b0010_01??: d.cfg.tempComp = cmdByte[1:0];
					8'b0010_10??: d.cfg.powerCtl = cmdByte[1:0];
					8'b0100_????: d.cfg.scrollLine[3:0] = cmdByte[3:0];
					8'b0101_????: d.cfg.scrollLine[7:4] = cmdByte[3:0];
					8'b0110_????: d.cfg.rowPointer[3:0] = cmdByte[3:0];
					8'b0111_????: d.cfg.rowPointer[7:4] = cmdByte[3:0];
					8'b1000_010?:
						d.cfg.panelCtlField[PCF_PARTIAL] = cmdByte[0];
					8'b1000_1???:
						d.cfg.addrIncrementCtl[2:0] = cmdByte[2:0];
					8'b1010_00??:
						d.cfg.panelCtlField[4:3] = cmdByte[1:0];
					8'b1010_01??:
						// All-pixel-on and inverse share one pattern
						d.cfg.displayCtlFlags[cmdByte[1] ? 0 : 1] =
							cmdByte[0];
					8'b1010_1???:
						d.cfg.displayCtlFlags[4:2] = cmdByte[2:0];
					8'b1100_0???:
						d.cfg.panelCtlField[2:0] = cmdByte[2:0];
					8'b1101_000?:
						d.cfg.panelCtlField[PCF_PATTERN] = cmdByte[0];
					8'b1101_01??:
						d.cfg.panelCtlField[7:6] = cmdByte[1:0];
					8'b1101_1???: d.cfg.commonScanFunc = cmdByte[2:0];
					8'b1110_10??: d.cfg.biasRatio = cmdByte[1:0];
					8'b1111_100?:
						d.cfg.addrIncrementCtl[AIC_WINMODE] = cmdByte[0];
					OP_SYSRST: begin
						// Full field reset, parameter expectation gone
						d.cfg = CFG_RESET;
						d.paramPending = 1'b0;
					end
					OP_NOP: d.paramPending = 1'b0;
					OP_APC0, OP_APC1, OP_POT, OP_FIXED, OP_NIV,
					OP_NVM_OP, OP_NVM_MASK, OP_CEN, OP_DST, OP_DEN,
					8'b1110_01??, 8'b1111_01??:
						d.paramPending = 1'b1;
					// Unlisted patterns change no field; only the status index restarts
					default: d.paramPending = 1'b0;
				endcase
			end
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{cfg: CFG_RESET, default: '0};
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign link.rdata = q.rdData;
	assign link.rdValid = q.rdValid;
	assign memWrStrobe = q.memWrStrobe;
	assign memWrData = q.memWrData;
	assign cfg = q.cfg;

endmodule

// ---- design/hcd_pkg.sv ----
package hcd_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10; // core_clk at 100 MHz
	localparam int RST_LOW_US = 3; // Least reset low width
	localparam int RST_WAIT_MS = 10; // Least reset to first strobe
	// Least times round up to whole cycles
	localparam int RST_LOW_CYCLES =
		(RST_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_WAIT_CYCLES =
		(RST_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Host register map (APB, byte addresses)
	// ************************************************************
	localparam logic [7:0] HOST_CMD_OFS = 8'h00; // Issue a link cycle
	localparam logic [7:0] HOST_STAT_OFS = 8'h04; // Busy and ready
	localparam logic [7:0] HOST_RDATA_OFS = 8'h08; // Last read word
	localparam int CMD_CD_BIT = 16; // Command/data select
	localparam int CMD_RD_BIT = 17; // Read when set
	localparam int CMD_TOKEN_BIT = 18; // Serial token level
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_READY_BIT = 1;

	// ************************************************************
	// Identity and status layout
	// ************************************************************
	localparam logic [3:0] PRODUCT_CODE = 4'h5; // Arbitrary value
	localparam logic VERSION_BIT = 1'b0; // Arbitrary value
	localparam logic [1:0] STAT_LAST_IDX = 2'h2; // Three status bytes

	// ************************************************************
	// Field positions and opcodes
	// ************************************************************
	localparam int PCF_PARTIAL = 8; // Partial display enable
	localparam int PCF_PATTERN = 5; // Colour pattern
	localparam int AIC_WINMODE = 3; // Window program mode
	localparam int NVM_SHARE_BIT = 3; // Selects shared opcode meaning
	localparam logic [7:0] OP_APC0 = 8'h30;
	localparam logic [7:0] OP_APC1 = 8'h31;
	localparam logic [7:0] OP_POT = 8'h81;
	localparam logic [7:0] OP_FIXED = 8'h90;
	localparam logic [7:0] OP_NIV = 8'hc8;
	localparam logic [7:0] OP_NVM_OP = 8'hb8;
	localparam logic [7:0] OP_NVM_MASK = 8'hb9;
	localparam logic [7:0] OP_SYSRST = 8'he2;
	localparam logic [7:0] OP_NOP = 8'he3;
	localparam logic [7:0] OP_CEN = 8'hf1;
	localparam logic [7:0] OP_DST = 8'hf2;
	localparam logic [7:0] OP_DEN = 8'hf3;

	// ************************************************************
	// Control fields
	// ************************************************************
	typedef struct packed {
		logic [6:0] columnPointer;
		logic [7:0] rowPointer;
		logic [7:0] scrollLine;
		logic [1:0] tempComp;
		logic [1:0] powerCtl;
		logic [1:0] biasRatio;
		logic [7:0] biasPotValue;
		logic [3:0] addrIncrementCtl;
		logic [8:0] panelCtlField;
		logic [4:0] lineInversionCount;
		logic [4:0] displayCtlFlags;
		logic [2:0] commonScanFunc;
		logic [7:0] lastCommonLine;
		logic [7:0] partialStartLine;
		logic [7:0] partialEndLine;
		logic [3:0][7:0] windowRegs; // Start col/row, end col/row
		logic [3:0][7:0] nvmRegs; // Shared-opcode alternates
		logic [4:0] nvmProgramCtl;
		logic [6:0] nvmWriteMask;
	} hcd_cfg_t;

	localparam hcd_cfg_t CFG_RESET = '{
		columnPointer: 7'h00,
		rowPointer: 8'h00,
		scrollLine: 8'h00,
		tempComp: 2'h0,
		powerCtl: 2'h2,
		biasRatio: 2'h3,
		biasPotValue: 8'h40,
		addrIncrementCtl: 4'h1,
		panelCtlField: 9'h090,
		lineInversionCount: 5'h1d,
		displayCtlFlags: 5'h18,
		commonScanFunc: 3'h0,
		lastCommonLine: 8'h9f,
		partialStartLine: 8'h00,
		partialEndLine: 8'h9f,
		windowRegs: {8'h9f, 8'h7f, 8'h00, 8'h00},
		nvmRegs: {8'h00, 8'h00, 8'h00, 8'h00},
		nvmProgramCtl: 5'h10,
		nvmWriteMask: 7'h00
	};

	typedef enum logic [1:0] {
		HST_RST_LOW, HST_RST_WAIT, HST_IDLE, HST_RD_WAIT
	} hcd_host_state_t;

endpackage

// ---- design/hcd_link_if.sv ----
`timescale 1ns/1ps
interface hcd_link_if;
	logic hwResetB; // Panel reset, active low
	logic strobe; // One bus cycle, one clock wide
	logic rdNotWr; // High for a read cycle
	logic cmdDataSelect; // High for display data
	logic tokenCd; // Serial nine-bit token data flag
	logic [15:0] wdata; // Write data
	logic [15:0] rdata; // Read data
	logic rdValid; // Read data valid pulse

	modport dev (
		input hwResetB, strobe, rdNotWr, cmdDataSelect, tokenCd, wdata,
		output rdata, rdValid
	);
	modport host (
		output hwResetB, strobe, rdNotWr, cmdDataSelect, tokenCd, wdata,
		input rdata, rdValid
	);
endinterface

// ---- design/hcd_host.sv ----
`timescale 1ns/1ps
module hcd_host #(
	parameter int RESET_WAIT_CYCLES = hcd_pkg::RST_WAIT_CYCLES
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to the device
	hcd_link_if.host link
);
	import hcd_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		hcd_host_state_t st; // Sequencer state
		logic [19:0] cnt; // Reset timing counter
		logic hwResetB; // Panel reset drive
		logic strobe; // Link cycle pulse
		logic rdNotWr;
		logic cmdDataSelect;
		logic tokenCd;
		logic [15:0] wdata;
		logic [15:0] rdWord; // Last read answer
		logic [31:0] prdata; // APB read data
	} hcd_host_state_s_t;

	hcd_host_state_s_t q; // Registered state
	hcd_host_state_s_t d; // Next state

	// ************************************************************
	// Sequencer and APB decode
	// ************************************************************
	always_comb begin
		logic wrAcc; // APB write access phase
		logic rdAcc; // APB read access phase
		wrAcc = psel && penable && pwrite;
		rdAcc = psel && penable && !pwrite;
		d = q;
		d.strobe = 1'b0;
		unique case (q.st)
			HST_RST_LOW: begin
				// Panel reset held low for its least width
				d.hwResetB = 1'b0;
				d.cnt = q.cnt + 20'h1;
				if (q.cnt == 20'(RST_LOW_CYCLES - 1)) begin
					d.st = HST_RST_WAIT;
					d.cnt = 20'h0;
					d.hwResetB = 1'b1;
				end
			end
			HST_RST_WAIT: begin
				// No strobe until the settling time has passed
				d.cnt = q.cnt + 20'h1;
				if (q.cnt == 20'(RESET_WAIT_CYCLES - 1)) begin
					d.st = HST_IDLE;
				end
			end
			HST_IDLE: begin
				// A command write starts one link cycle
				if (wrAcc && paddr == HOST_CMD_OFS) begin
					d.strobe = 1'b1;
					d.wdata = pwdata[15:0];
					d.cmdDataSelect = pwdata[CMD_CD_BIT];
					d.rdNotWr = pwdata[CMD_RD_BIT];
					d.tokenCd = pwdata[CMD_TOKEN_BIT];
					if (pwdata[CMD_RD_BIT]) begin
						d.st = HST_RD_WAIT;
					end
				end
			end
			HST_RD_WAIT: begin
				// Hold until the device answers
				if (link.rdValid) begin
					d.rdWord = link.rdata;
					d.st = HST_IDLE;
				end
			end
		endcase
		// Registered read data for the next access
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				HOST_STAT_OFS: d.prdata = {30'h0,
					q.st == HST_IDLE, q.st != HST_IDLE};
				HOST_RDATA_OFS: d.prdata = {16'h0, q.rdWord};
				default: d.prdata = 32'h0;
			endcase
		end
		if (rdAcc) begin
			d.prdata = q.prdata;
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{st: HST_RST_LOW, default: '0};
		end else begin
			q <= d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata = q.prdata;
	assign pready = 1'b1; // Zero-wait slave
	assign pslverr = 1'b0;
	assign link.hwResetB = q.hwResetB;
	assign link.strobe = q.strobe;
	assign link.rdNotWr = q.rdNotWr;
	assign link.cmdDataSelect = q.cmdDataSelect;
	assign link.tokenCd = q.tokenCd;
	assign link.wdata = q.wdata;

endmodule

// ---- verification/hcd_link_asserts.sv ----
`timescale 1ns/1ps
module hcd_link_asserts #(
	parameter int RESET_WAIT_CYCLES = 50
) (
	// Clock and reset
	input logic core_clk,
	input logic rst_b,
	// Link signals
	input logic hwResetB,
	input logic strobe,
	input logic rdNotWr,
	input logic cmdDataSelect,
	input logic tokenCd,
	input logic [15:0] wdata,
	input logic [15:0] rdata,
	input logic rdValid
);
	import hcd_pkg::*;
	// ****
	// Helper counters
	// ****
	// One cycle of slack: the rise may land on the last counted edge
	localparam int LOW_MIN = RST_LOW_CYCLES - 1;
	logic [15:0] lowCnt_q; // Low cycles of panel reset
	logic [31:0] highCnt_q; // Cycles since panel reset rose
	// Each count lives only while its level lasts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lowCnt_q <= 16'h0;
			highCnt_q <= 32'h0;
		end else begin
			lowCnt_q <= hwResetB ? 16'h0 : lowCnt_q + 16'h1;
			highCnt_q <= hwResetB ? highCnt_q + 32'h1 : 32'h0;
		end
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// ****
	// Assertions
	// ****
	chk_read_answer: assert property (strobe && rdNotWr |=> rdValid)
		else $error("read cycle got no answer");
	chk_valid_cause: assert property (
		rdValid |-> $past(strobe) && $past(rdNotWr))
		else $error("read answer without a read cycle");
	chk_write_quiet: assert property (strobe && !rdNotWr |=> !rdValid)
		else $error("write cycle answered like a read");
	chk_valid_single: assert property (rdValid |=> !rdValid)
		else $error("read answer longer than one cycle");
	chk_rdata_holds: assert property (!rdValid |-> $stable(rdata))
		else $error("read data moved without an answer");
	chk_strobe_pulse: assert property (strobe |=> !strobe)
		else $error("bus cycles merged");
	chk_quiet_in_reset: assert property (!hwResetB |-> !strobe)
		else $error("bus cycle during panel reset");
	chk_reset_width: assert property (
		$rose(hwResetB) |-> lowCnt_q >= LOW_MIN)
		else $error("panel reset pulse too short");
	chk_reset_wait: assert property (
		strobe |-> highCnt_q >= RESET_WAIT_CYCLES)
		else $error("bus cycle too soon after panel reset");
	// ****
	// Covers
	// ****
	cover property (strobe && rdNotWr && cmdDataSelect);
	cover property (strobe && !cmdDataSelect && wdata[7:0] == OP_POT);
	cover property (strobe && tokenCd);
	cover property ($rose(hwResetB));
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import hcd_pkg::*;
	// ****
	// Signals
	// ****
	localparam int WAIT_CYCLES = 50; // Short reset wait for sim
	localparam logic [7:0] FIELD_OPS [20] = '{8'h0a, 8'h15, 8'h63, 8'h7a,
		8'h45, 8'h5b, 8'h26, 8'h2b, 8'he9, 8'h8e, 8'ha1, 8'h85, 8'hc3,
		8'hd1, 8'hd5, 8'hdb, 8'ha5, 8'ha7, 8'had, 8'hf9};
	logic core_clk = 1'b0; // 100 MHz
	logic rst_b = 1'b0; // Held low from the start
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr; // Slave error, never raised
	logic busWide16 = 1'b0; // Bus width strap
	logic serialNineBitMode = 1'b0; // Serial token mode strap
	logic [1:0] idPinState = 2'h2;
	logic [1:0] moduleId = 2'h1;
	logic memWrStrobe;
	logic [15:0] memWrData;
	logic [15:0] memRdData = 16'hc3a5; // Fixed memory read word
	hcd_cfg_t cfg;
	hcd_cfg_t e; // Expected control fields
	int mismatches = 0;
	int totalChecks = 0;
	int cycles = 0;
	int wrCount = 0; // Memory writes seen
	logic [15:0] lastWr = 16'h0; // Last memory write word
	logic [31:0] q; // Last APB read word
	// ****
	// Design
	// ****
	hcd_link_if link ();
	hcd_host #(.RESET_WAIT_CYCLES(WAIT_CYCLES)) hcd_host_inst (
		.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	hcd_device hcd_device_inst (
		.core_clk(core_clk), .rst_b(rst_b), .link(link),
		.busWide16(busWide16), .serialNineBitMode(serialNineBitMode),
		.idPinState(idPinState), .moduleId(moduleId),
		.memWrStrobe(memWrStrobe), .memWrData(memWrData),
		.memRdData(memRdData), .cfg(cfg));
	hcd_link_asserts #(.RESET_WAIT_CYCLES(WAIT_CYCLES))
		hcd_link_asserts_inst (
		.core_clk(core_clk), .rst_b(rst_b), .hwResetB(link.hwResetB),
		.strobe(link.strobe), .rdNotWr(link.rdNotWr),
		.cmdDataSelect(link.cmdDataSelect), .tokenCd(link.tokenCd),
		.wdata(link.wdata), .rdata(link.rdata), .rdValid(link.rdValid));
	// Clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Memory write monitor and hang guard
	always @(posedge core_clk) begin
		cycles++;
		if (memWrStrobe === 1'b1) begin
			wrCount++;
			lastWr = memWrData;
		end
		if (cycles == 10000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ****
	// Bus tasks
	// ****
	// One APB transfer; read word lands in q
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One link cycle, then poll until the host is idle
	task automatic link_op(input logic rd, cd, tok, input logic [15:0] d);
		apb(1'b1, HOST_CMD_OFS, {13'h0, tok, rd, cd, d});
		do apb(1'b0, HOST_STAT_OFS, 32'h0);
		while (q[STAT_BUSY_BIT] !== 1'b0);
	endtask
	task automatic cmd(input logic [7:0] b);
		link_op(1'b0, 1'b0, 1'b0, {8'h00, b});
	endtask
	task automatic cmd2(input logic [7:0] op, p);
		cmd(op);
		cmd(p);
	endtask
	task automatic rd_link(input logic cd);
		link_op(1'b1, cd, 1'b0, 16'h0);
		apb(1'b0, HOST_RDATA_OFS, 32'h0);
	endtask
	// Reset, then wait until the host reports ready
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		do apb(1'b0, HOST_STAT_OFS, 32'h0);
		while (q[STAT_READY_BIT] !== 1'b1);
	endtask
	// ****
	// Compares
	// ****
	task automatic check_cfg(input string n);
		totalChecks++;
		if (cfg !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, cfg);
		end
	endtask
	task automatic check_word(input string n, input logic [15:0] x, y);
		totalChecks++;
		if (x !== y) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, x, y);
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_defaults;
		e = CFG_RESET;
		check_cfg("defaults");
		// Host bus answers at once and never flags an error
		check_word("ready", 16'h1, {15'h0, pready});
		check_word("slave error", 16'h0, {15'h0, pslverr});
		$display("test defaults done");
	endtask
	// Status bytes follow the current fields and straps
	task automatic t_status;
		logic [7:0] b [3];
		// Display enable is the low bit of the enable group
		b[0] = {1'b0, e.panelCtlField[2:1], e.addrIncrementCtl[AIC_WINMODE],
			e.displayCtlFlags[2], 3'h0};
		b[1] = {VERSION_BIT, e.biasPotValue[6:0]};
		b[2] = {PRODUCT_CODE, idPinState, moduleId};
		cmd(OP_NOP);
		for (int i = 0; i < 4; i++) begin
			rd_link(1'b0);
			check_word("status", {8'h0, b[i % 3]}, q[15:0]);
		end
		check_cfg("nop");
		$display("test status done");
	endtask
	task automatic t_fields;
		foreach (FIELD_OPS[i])
			cmd(FIELD_OPS[i]);
		e.columnPointer = 7'h5a;
		e.rowPointer = 8'ha3;
		e.scrollLine = 8'hb5;
		e.tempComp = 2'h2;
		e.powerCtl = 2'h3;
		e.biasRatio = 2'h1;
		e.addrIncrementCtl = 4'he;
		e.panelCtlField = 9'h16b;
		e.displayCtlFlags = 5'h17;
		e.commonScanFunc = 3'h3;
		check_cfg("fields");
		$display("test fields done");
	endtask
	// Wide bus: junk upper byte, data cycle inside a pending pair
	task automatic t_two_byte;
		int n;
		n = wrCount;
		busWide16 <= 1'b1;
		link_op(1'b0, 1'b0, 1'b0, {8'ha5, OP_POT});
		link_op(1'b0, 1'b1, 1'b0, 16'h1234);
		link_op(1'b0, 1'b0, 1'b0, 16'h5a8b);
		check_word("mem data", 16'h1234, lastWr);
		check_word("mem writes", 16'(n + 1), 16'(wrCount));
		rd_link(1'b1);
		check_word("mem read", memRdData, q[15:0]);
		busWide16 <= 1'b0;
		cmd2(OP_CEN, 8'h50);
		cmd2(OP_DST, 8'h11);
		cmd2(OP_DEN, 8'h22);
		cmd2(OP_NIV, 8'h0a);
		e.biasPotValue = 8'h8b;
		e.lastCommonLine = 8'h50;
		e.partialStartLine = 8'h11;
		e.partialEndLine = 8'h22;
		e.lineInversionCount = 5'h0a;
		check_cfg("two byte");
		$display("test two byte done");
	endtask
	task automatic t_shared;
		cmd2(8'hf4, 8'h11);
		cmd2(8'hf7, 8'h33);
		cmd2(OP_NVM_OP, 8'h18);
		cmd2(8'hf4, 8'h44);
		cmd2(OP_NVM_MASK, 8'h55);
		e.windowRegs[0] = 8'h11;
		e.windowRegs[3] = 8'h33;
		e.nvmProgramCtl = 5'h18;
		e.nvmRegs[0] = 8'h44;
		e.nvmWriteMask = 7'h55;
		check_cfg("shared");
		$display("test shared done");
	endtask
	// Opcode reset, then a hardware reset with a pair pending
	task automatic t_sysrst;
		cmd(OP_SYSRST);
		e = CFG_RESET;
		check_cfg("system reset");
		cmd(OP_POT);
		do_reset;
		cmd(8'h25);
		e.tempComp = 2'h1;
		check_cfg("pending dropped");
		$display("test reset done");
	endtask
	// Token decides; the select pin says the opposite
	task automatic t_serial;
		int n;
		n = wrCount;
		serialNineBitMode <= 1'b1;
		link_op(1'b0, 1'b0, 1'b1, 16'h00aa);
		link_op(1'b0, 1'b1, 1'b0, 16'h0027);
		e.tempComp = 2'h3;
		check_word("serial writes", 16'(n + 1), 16'(wrCount));
		check_word("serial data", 16'h00aa, {8'h0, lastWr[7:0]});
		check_cfg("serial cmd");
		serialNineBitMode <= 1'b0;
		$display("test serial done");
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		do_reset;
		t_defaults;
		t_status;
		t_fields;
		t_two_byte;
		t_status;
		t_shared;
		t_sysrst;
		t_serial;
		give_verdict();
	end
endmodule
